// ### src/t1_rx_elastic_pkg.sv
// Constants for the receive elastic store: map, field layout, sizes, timing.
package t1_rx_elastic_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
	localparam logic [ADDR_W-1:0] SLOT_OFFSET_OFFSET = 8'h04;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h08;
	localparam logic [ADDR_W-1:0] CLEAR_OFFSET = 8'h0c;
	localparam logic [ADDR_W-1:0] ENABLE_OFFSET = 8'h10;
	localparam logic [ADDR_W-1:0] POINTER_OFFSET = 8'h14;
	// Control register fields
	localparam int RX_SIZE_LSB = 0;
	localparam int TX_SIZE_LSB = 2;
	localparam int TRANSLATE_BIT = 4;
	localparam int JITTER_SEL_BIT = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	// Offset register fields: time slot offset and clock slot offset
	localparam int SLOT_LSB = 3;
	localparam logic [7:0] SLOT_OFFSET_RESET = 8'h00;
	// Status, clear and enable share one layout
	localparam int POS_SLIP_BIT = 0;
	localparam int NEG_SLIP_BIT = 1;
	localparam logic [1:0] STATUS_RESET = 2'h0;
	localparam logic [1:0] ENABLE_RESET = 2'h0;
	// Store size codes
	localparam logic [1:0] SIZE_TWO_FRAMES = 2'b00;
	localparam logic [1:0] SIZE_ONE_FRAME = 2'b01;
	localparam logic [1:0] SIZE_SHORT = 2'b10;
	localparam logic [1:0] SIZE_BYPASS = 2'b11;
	// Store depth in 8-bit words: 386, 193 and 96 bits
	localparam logic [5:0] DEPTH_TWO_FRAMES = 6'd50;
	localparam logic [5:0] DEPTH_ONE_FRAME = 6'd25;
	localparam logic [5:0] DEPTH_SHORT = 6'd12;
	// Read base step per system frame: 25 words modulo depth
	localparam logic [5:0] STEP_TWO_FRAMES = 6'd25;
	localparam logic [5:0] STEP_ONE_FRAME = 6'd0;
	localparam logic [5:0] STEP_SHORT = 6'd1;
	localparam logic [5:0] SLIP_LIMIT = 6'd2;
	localparam logic [7:0] LAST_SYSTEM_BIT = 8'd255;
	localparam logic [7:0] UNEQUIPPED = 8'hff;
	localparam int SYNC_STAGES = 3;
endpackage

// ### src/t1_rx_elastic_buffer.sv
// Receive elastic store with slip control, slot translation and register port.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Size 00: two-frame store, one frame delay
// - Size 01: one-frame store, 96-bit delay
// - Size 10: 96-bit store, mode 1 unsupported
// - Size 11: store bypassed entirely
// - Receive size held apart from transmit size
// - Route bits packed into words, written circularly
// - Read on system clock, sync plus offsets
// - Bypass: no offsets, route clock drives output
// - Bypass: sync pulse and slot assigner ignored
// - Slip when read nears write pointer
// - Positive slip repeats, negative slip skips
// - Slips except bypass; reposition half-store back
// - Separate positive and negative slip flags
// - 24 channels to 32 slots, spare FF
// - Mode 0: every fourth slot spare
// - Mode 1: channel n in slot n
// - Jitter oscillator clock may drive reading
module t1_rx_elastic_buffer
	import t1_rx_elastic_pkg::*;
(
	input wire logic clk, // System clock, 125 MHz
	input wire logic reset, // Asynchronous, active high
	input wire logic clockEnable, // Freezes all state while low
	input wire logic [t1_rx_elastic_pkg::ADDR_W-1:0] address, // Register byte address
	input wire logic [t1_rx_elastic_pkg::DATA_W-1:0] writeData, // Register write data
	input wire logic writeStrobe, // One-cycle write
	input wire logic readStrobe, // One-cycle read
	output logic [t1_rx_elastic_pkg::DATA_W-1:0] readData, // Valid the cycle after readStrobe
	input wire logic routeClock, // Recovered route clock pin
	input wire logic routeData, // Unipolar received data pin
	input wire logic routeFrameStart, // Framer mark: current bit is framing bit
	input wire logic systemReceiveClock, // Backplane receive clock pin
	input wire logic systemReceiveSyncPulse, // Backplane frame sync pin
	input wire logic rxJitterOscillatorClock, // De-jittered receive clock pin
	output logic receiveSerialOutput, // Serial receive data
	output logic interruptRequest // High while an enabled flag is set
);
	import t1_rx_elastic_pkg::*;

	localparam int PINS = 6;
	localparam int P_RCLK = 0;
	localparam int P_RDATA = 1;
	localparam int P_RFRAME = 2;
	localparam int P_SCLK = 3;
	localparam int P_SYNC = 4;
	localparam int P_JCLK = 5;

	logic [PINS-1:0] pinRaw;
	logic [PINS-1:0] pinLevel_reg;
	logic [PINS-1:0] pinRise;
	logic [5:0] ctrl_reg;
	logic [7:0] slotOffset_reg;
	logic [1:0] status_reg;
	logic [1:0] status_next;
	logic [1:0] enable_reg;
	logic sizeChanged_reg;
	logic [1:0] rxSize;
	logic bypass;
	logic translateMode;
	logic [5:0] depth;
	logic [5:0] frameStep;
	logic [5:0] half;
	logic [7:0] store [0:49];
	logic [5:0] wrPtr_reg;
	logic [5:0] wrPtrInc;
	logic [5:0] wrGray_reg;
	logic [5:0] wrCopy_reg;
	logic [6:0] wrShift_reg;
	logic [2:0] wrBitCount_reg;
	logic [5:0] rdBase_reg;
	logic [7:0] rdBitCount_reg;
	logic [7:0] rdShift_reg;
	logic readEdge;
	logic [4:0] sysSlot;
	logic [5:0] channel;
	logic equipped;
	logic [5:0] rdIndex;
	logic [7:0] rdWord;
	logic [5:0] nextBase;
	logic [5:0] aheadWords;
	logic frameEnd;
	logic posSlip;
	logic negSlip;

	assign pinRaw = {rxJitterOscillatorClock, systemReceiveSyncPulse, systemReceiveClock,
		routeFrameStart, routeData, routeClock};

	function automatic logic [5:0] wrapAdd(input logic [5:0] a, input logic [5:0] b, input logic [5:0] d);
		logic [6:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= {1'b0, d}) begin
			s = s - {1'b0, d};
		end
		return s[5:0];
	endfunction

	function automatic logic [5:0] wrapSub(input logic [5:0] a, input logic [5:0] b, input logic [5:0] d);
		logic [6:0] s;
		s = {1'b0, a} + {1'b0, d} - {1'b0, b};
		if (s >= {1'b0, d}) begin
			s = s - {1'b0, d};
		end
		return s[5:0];
	endfunction

	function automatic logic [5:0] grayToBin(input logic [5:0] g);
		logic [5:0] b;
		b = '0;
		b[5] = g[5];
		for (int i = 4; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// Three-stage pin sampling; a change counts once stages two and three agree
	genvar gp;
	generate
		for (gp = 0; gp < PINS; gp++) begin : g_pin
			logic [SYNC_STAGES-1:0] stage_reg;
			logic level_reg;
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					stage_reg <= '0;
					level_reg <= 1'b0;
				end else if (clockEnable) begin
					stage_reg <= {stage_reg[SYNC_STAGES-2:0], pinRaw[gp]};
					if (stage_reg[1] == stage_reg[2]) begin
						level_reg <= stage_reg[2];
					end
				end
			end
			// One process per bit owns the level; the vector is only a view
			assign pinLevel_reg[gp] = level_reg;
			assign pinRise[gp] = clockEnable && (stage_reg[1] == stage_reg[2]) && stage_reg[2] && !pinLevel_reg[gp];
		end
	endgenerate

	// Mode decode
	assign rxSize = ctrl_reg[RX_SIZE_LSB +: 2];
	assign bypass = (rxSize == SIZE_BYPASS);
	assign translateMode = ctrl_reg[TRANSLATE_BIT] && (rxSize != SIZE_SHORT);

	always_comb begin
		case (rxSize)
			SIZE_ONE_FRAME: begin
				depth = DEPTH_ONE_FRAME;
				frameStep = STEP_ONE_FRAME;
			end
			SIZE_SHORT: begin
				depth = DEPTH_SHORT;
				frameStep = STEP_SHORT;
			end
			default: begin
				depth = DEPTH_TWO_FRAMES;
				frameStep = STEP_TWO_FRAMES;
			end
		endcase
	end
	assign half = {1'b0, depth[5:1]};

	// Register writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_reg <= CTRL_RESET;
			slotOffset_reg <= SLOT_OFFSET_RESET;
			enable_reg <= ENABLE_RESET;
			sizeChanged_reg <= 1'b0;
		end else if (clockEnable) begin
			sizeChanged_reg <= 1'b0;
			if (writeStrobe) begin
				if (address == CTRL_OFFSET) begin
					ctrl_reg <= writeData[5:0];
					sizeChanged_reg <= (writeData[RX_SIZE_LSB +: 2] != rxSize);
				end else if (address == SLOT_OFFSET_OFFSET) begin
					slotOffset_reg <= writeData[7:0];
				end else if (address == ENABLE_OFFSET) begin
					enable_reg <= writeData[1:0];
				end
			end
		end
	end

	// Register reads, answered the cycle after the strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readData <= '0;
		end else if (clockEnable) begin
			readData <= '0;
			if (readStrobe) begin
				if (address == CTRL_OFFSET) begin
					readData <= {26'h0, ctrl_reg};
				end else if (address == SLOT_OFFSET_OFFSET) begin
					readData <= {24'h0, slotOffset_reg};
				end else if (address == STATUS_OFFSET) begin
					readData <= {30'h0, status_reg};
				end else if (address == ENABLE_OFFSET) begin
					readData <= {30'h0, enable_reg};
				end else if (address == POINTER_OFFSET) begin
					readData <= {18'h0, rdBitCount_reg, rdBase_reg};
				end
			end
		end
	end

	// Write side: bits packed into slot words on the route clock
	assign wrPtrInc = wrapAdd(wrPtr_reg, 6'd1, depth);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wrPtr_reg <= '0;
			wrGray_reg <= '0;
			wrShift_reg <= '0;
			wrBitCount_reg <= '0;
		end else if (clockEnable) begin
			if (sizeChanged_reg) begin
				wrPtr_reg <= '0;
				wrGray_reg <= '0;
				wrBitCount_reg <= '0;
			end else if (pinRise[P_RCLK] && !bypass) begin
				if (pinLevel_reg[P_RFRAME]) begin
					wrPtr_reg <= wrPtrInc;
					wrGray_reg <= wrPtrInc ^ (wrPtrInc >> 1);
					wrBitCount_reg <= '0;
				end else begin
					wrShift_reg <= {wrShift_reg[5:0], pinLevel_reg[P_RDATA]};
					wrBitCount_reg <= wrBitCount_reg + 3'd1;
					if (wrBitCount_reg == 3'd7) begin
						wrPtr_reg <= wrPtrInc;
						wrGray_reg <= wrPtrInc ^ (wrPtrInc >> 1);
					end
				end
			end
		end
	end

	// Store words; framing bit word padded with ones
	always_ff @(posedge clk) begin
		if (clockEnable && pinRise[P_RCLK] && !bypass && !sizeChanged_reg) begin
			if (pinLevel_reg[P_RFRAME]) begin
				store[wrPtr_reg] <= {pinLevel_reg[P_RDATA], 7'h7f};
			end else if (wrBitCount_reg == 3'd7) begin
				store[wrPtr_reg] <= {wrShift_reg, pinLevel_reg[P_RDATA]};
			end
		end
	end

	// Read side sees only the gray copy, decoded before registering
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wrCopy_reg <= '0;
		end else if (clockEnable) begin
			wrCopy_reg <= grayToBin(wrGray_reg);
		end
	end

	// Slot translation
	assign readEdge = ctrl_reg[JITTER_SEL_BIT] ? pinRise[P_JCLK] : pinRise[P_SCLK];
	assign sysSlot = rdBitCount_reg[7:3];
	always_comb begin
		channel = '0;
		equipped = 1'b1;
		if (translateMode) begin
			if (sysSlot > 5'd24) begin
				equipped = 1'b0;
			end else begin
				channel = {1'b0, sysSlot};
			end
		end else if (sysSlot != 5'd0 && sysSlot[1:0] == 2'b00) begin
			equipped = 1'b0;
		end else begin
			channel = {1'b0, sysSlot} - {3'b0, sysSlot[4:2]};
		end
	end
	assign rdIndex = wrapAdd(rdBase_reg, (channel >= depth) ? channel - depth : channel, depth);
	assign rdWord = equipped ? store[rdIndex] : UNEQUIPPED;

	// Slip check at each system frame end
	assign frameEnd = readEdge && (rdBitCount_reg == LAST_SYSTEM_BIT) && !bypass;
	assign nextBase = wrapAdd(rdBase_reg, frameStep, depth);
	assign aheadWords = wrapSub(wrCopy_reg, nextBase, depth);
	assign posSlip = frameEnd && (aheadWords < SLIP_LIMIT);
	assign negSlip = frameEnd && !posSlip && (aheadWords > depth - SLIP_LIMIT);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdBase_reg <= '0;
		end else if (clockEnable) begin
			if (sizeChanged_reg) begin
				rdBase_reg <= '0;
			end else if (posSlip || negSlip) begin
				rdBase_reg <= wrapSub(wrCopy_reg, half, depth);
			end else if (frameEnd) begin
				rdBase_reg <= nextBase;
			end
		end
	end

	// Read bit counter, realigned by the sync pulse plus offsets
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdBitCount_reg <= '0;
		end else if (clockEnable && !bypass) begin
			if (pinRise[P_SYNC]) begin
				rdBitCount_reg <= {slotOffset_reg[SLOT_LSB +: 5], slotOffset_reg[2:0]};
			end else if (readEdge) begin
				rdBitCount_reg <= rdBitCount_reg + 8'd1;
			end
		end
	end

	// Serializer; bypass passes route data straight on the route clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdShift_reg <= UNEQUIPPED;
			receiveSerialOutput <= 1'b1;
		end else if (clockEnable) begin
			if (bypass) begin
				if (pinRise[P_RCLK]) begin
					receiveSerialOutput <= pinLevel_reg[P_RDATA];
				end
			end else if (readEdge) begin
				if (rdBitCount_reg[2:0] == 3'd0) begin
					receiveSerialOutput <= rdWord[7];
					rdShift_reg <= {rdWord[6:0], 1'b1};
				end else begin
					receiveSerialOutput <= rdShift_reg[7];
					rdShift_reg <= {rdShift_reg[6:0], 1'b1};
				end
			end
		end
	end

	// Sticky slip flags; a new event wins over a clear in the same cycle
	always_comb begin
		status_next = status_reg;
		if (writeStrobe && address == CLEAR_OFFSET) begin
			status_next = status_reg & ~writeData[1:0];
		end
		if (posSlip) begin
			status_next[POS_SLIP_BIT] = 1'b1;
		end
		if (negSlip) begin
			status_next[NEG_SLIP_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status_reg <= STATUS_RESET;
			interruptRequest <= 1'b0;
		end else if (clockEnable) begin
			status_reg <= status_next;
			interruptRequest <= |(status_next & enable_reg);
		end
	end
endmodule

`default_nettype wire

// ### tb/t1_rx_elastic_assertions.sv
// Port checker for the receive elastic store.
`timescale 1ns/100ps
`default_nettype none
module t1_rx_elastic_assertions
	import t1_rx_elastic_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic reset, // Reset
	input wire logic clockEnable, // Run
	input wire logic [t1_rx_elastic_pkg::ADDR_W-1:0] address, // Address
	input wire logic [t1_rx_elastic_pkg::DATA_W-1:0] writeData, // Data in
	input wire logic writeStrobe, // Write
	input wire logic readStrobe, // Read
	input wire logic [t1_rx_elastic_pkg::DATA_W-1:0] readData, // Data out
	input wire logic routeClock, // Route clock
	input wire logic routeData, // Route bit
	input wire logic receiveSerialOutput, // Serial out
	input wire logic interruptRequest // Interrupt
);
	logic [5:0] ctrl_reg;
	logic [1:0] en_reg;
	logic rd;
	logic wr;
	assign rd = readStrobe && clockEnable;
	assign wr = writeStrobe && clockEnable;
	// Shadows, so checks know mode and mask
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_reg <= CTRL_RESET;
			en_reg <= ENABLE_RESET;
		end else if (wr && address == CTRL_OFFSET) begin
			ctrl_reg <= writeData[5:0];
		end else if (wr && address == ENABLE_OFFSET) begin
			en_reg <= writeData[1:0];
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	a_bypass_follows_route: assert property (ctrl_reg[1:0] == SIZE_BYPASS && $rose(routeClock)
		|-> ##[3:6] receiveSerialOutput == routeData) else $error("bypass bit");
	a_ctrl_readback: assert property (rd && address == CTRL_OFFSET |=> readData == {26'h0, $past(ctrl_reg)})
		else $error("ctrl readback");
	a_irq_follows_status: assert property (rd && address == STATUS_OFFSET
		|=> interruptRequest == |(readData[1:0] & $past(en_reg))) else $error("irq vs status");
	a_irq_masked_off: assert property (en_reg == 2'h0 && $past(en_reg) == 2'h0 |-> !interruptRequest)
		else $error("irq masked");
	a_status_upper_zero: assert property (rd && address == STATUS_OFFSET |=> readData[31:2] == 30'h0)
		else $error("status upper");
	a_idle_data_zero: assert property (!rd |=> readData == 32'h0) else $error("idle data");
	a_clear_reads_zero: assert property (rd && address == CLEAR_OFFSET |=> readData == 32'h0) else $error("clear read");
	a_release_state: assert property ($past(reset) |-> receiveSerialOutput && !interruptRequest && readData == 32'h0)
		else $error("release state");
	c_slip_seen: cover property (rd && address == STATUS_OFFSET ##1 readData[1:0] != 2'h0);
	c_irq_raised: cover property ($rose(interruptRequest));
	c_bypass_bit: cover property (ctrl_reg[1:0] == SIZE_BYPASS && $rose(routeClock));
endmodule
bind t1_rx_elastic_buffer t1_rx_elastic_assertions chk (.clk, .reset, .clockEnable, .address, .writeData,
	.writeStrobe, .readStrobe, .readData, .routeClock, .routeData, .receiveSerialOutput, .interruptRequest);
`default_nettype wire

// ### tb/t1_rx_highway_model.sv
// Backplane highway model: read clock, frame sync, serial bit monitor.
`timescale 1ns/100ps
`default_nettype none
module t1_rx_highway_model (
	input wire logic receiveSerialOutput, // Serial bits
	input wire logic runClock, // Clock allowed
	input wire logic runClear, // Restart count
	input var real halfPeriod, // Half period ns
	output logic systemReceiveClock, // Read clock
	output logic systemReceiveSyncPulse, // Frame sync
	output var int maxRun // Longest ones run
);
	int bitCount = 0;
	int run = 0;
	initial begin
		systemReceiveClock = 1'b0;
		systemReceiveSyncPulse = 1'b0;
		maxRun = 0;
		forever begin
			#(halfPeriod);
			if (runClock) begin
				systemReceiveClock = ~systemReceiveClock;
			end
			if (runClock && systemReceiveClock) begin
				// One sync per 256 bits, held a full period
				bitCount = (bitCount + 1) % 256;
				systemReceiveSyncPulse = bitCount == 0;
				run = receiveSerialOutput === 1'b1 && !runClear ? run + 1 : 0;
				maxRun = runClear ? 0 : run > maxRun ? run : maxRun;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/t1_rx_elastic_buffer_test.sv
// Bench for the receive elastic store: registers, slot maps, slips, bypass.
`timescale 1ns/100ps
`default_nettype none
module t1_rx_elastic_buffer_test;
	import t1_rx_elastic_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [ADDR_W-1:0] address = 8'h00;
	logic [ADDR_W-1:0] regs [3] = '{CTRL_OFFSET, SLOT_OFFSET_OFFSET, ENABLE_OFFSET};
	logic [DATA_W-1:0] masks [3] = '{32'h3f, 32'hff, 32'h3};
	logic [DATA_W-1:0] writeData = 32'h0;
	logic [DATA_W-1:0] readData;
	logic [DATA_W-1:0] got;
	logic [DATA_W-1:0] d;
	logic writeStrobe = 1'b0;
	logic readStrobe = 1'b0;
	logic routeClock = 1'b0;
	logic routeData = 1'b0;
	logic routeFrameStart = 1'b0;
	logic systemReceiveClock;
	logic systemReceiveSyncPulse;
	logic receiveSerialOutput;
	logic interruptRequest;
	logic runClock = 1'b1;
	logic runClear = 1'b0;
	logic zeroData = 1'b0;
	real halfPeriod = 30.2;
	int maxRun;
	int phase = 0;
	int bitNo = 0;
	int seed = 12;
	int num_errors = 0;
	int checks = 0;
	always #4 clk = ~clk;
	t1_rx_elastic_buffer uut (.clk, .reset, .clockEnable(1'b1), .address, .writeData, .writeStrobe, .readStrobe,
		.readData, .routeClock, .routeData, .routeFrameStart, .systemReceiveClock, .systemReceiveSyncPulse,
		.rxJitterOscillatorClock(systemReceiveClock), .receiveSerialOutput, .interruptRequest);
	t1_rx_highway_model far (.receiveSerialOutput, .runClock, .runClear, .halfPeriod, .systemReceiveClock,
		.systemReceiveSyncPulse, .maxRun);
	// Route bit per 10 clocks; data moves mid-low, stable around the rise
	always @(posedge clk) begin
		phase <= (phase + 1) % 10;
		routeClock <= phase < 5;
		if (phase == 7) begin
			routeData <= !zeroData && $random(seed) % 2 != 0;
			routeFrameStart <= bitNo == 0;
			bitNo <= (bitNo + 1) % 193;
		end
	end
	function automatic int longRun(input int m);
		return m ? 8 * (31 - 24) : 8; // Mode 1 spares a tail, mode 0 lone slots
	endfunction
	task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] v);
		address <= ad;
		writeData <= v;
		writeStrobe <= 1'b1;
		@(posedge clk);
		writeStrobe <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] ad);
		address <= ad;
		readStrobe <= 1'b1;
		@(posedge clk);
		readStrobe <= 1'b0;
		#1 got = readData;
		@(posedge clk);
	endtask
	task automatic rc(input string n, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
		rd(ad);
		chk(n, e, got);
	endtask
	task automatic waitFlag(input int b);
		for (int i = 0; i < 60; i++) begin
			repeat (500) @(posedge clk);
			rd(STATUS_OFFSET);
			if (got[b] === 1'b1) break;
		end
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#780000;
		num_errors++;
		end_of_test;
	end
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 3; i++) begin
			rc("reset value", regs[i], 32'h0);
		end
		rc("status reset", STATUS_OFFSET, 32'h0);
		rc("unmapped", 8'h18, 32'h0);
		wr(STATUS_OFFSET, 32'h3);
		rc("status ro", STATUS_OFFSET, 32'h0);
		rc("clear wo", CLEAR_OFFSET, 32'h0);
		for (int i = 0; i < 12; i++) begin
			d = $random(seed);
			wr(regs[i % 3], d);
			rc("readback", regs[i % 3], d & masks[i % 3]);
		end
		zeroData <= 1'b1;
		for (int t = 0; t < 2; t++) begin
			wr(CTRL_OFFSET, t ? 32'h30 : 32'h0);
			repeat (8000) @(posedge clk);
			runClear <= 1'b1;
			repeat (20) @(posedge clk);
			runClear <= 1'b0;
			repeat (6000) @(posedge clk);
			chk("longest ones run", longRun(t), maxRun);
		end
		// Short store keeps slip waits brief
		wr(CTRL_OFFSET, 32'(SIZE_SHORT));
		wr(ENABLE_OFFSET, 32'h0);
		halfPeriod = 28.0;
		wr(CLEAR_OFFSET, 32'h3);
		waitFlag(POS_SLIP_BIT);
		chk("positive slip", 32'h1, got);
		chk("masked irq", 32'h0, 32'(interruptRequest));
		wr(ENABLE_OFFSET, 32'h1);
		rd(STATUS_OFFSET);
		chk("irq", 32'h1, 32'(interruptRequest));
		halfPeriod = 32.0;
		repeat (2500) @(posedge clk);
		wr(CLEAR_OFFSET, 32'h3);
		waitFlag(NEG_SLIP_BIT);
		chk("negative slip", 32'h2, got);
		chk("masked irq", 32'h0, 32'(interruptRequest));
		wr(ENABLE_OFFSET, 32'h3);
		rd(STATUS_OFFSET);
		chk("irq", 32'h1, 32'(interruptRequest));
		wr(CTRL_OFFSET, 32'(SIZE_BYPASS));
		zeroData <= 1'b0;
		repeat (20) @(posedge clk);
		for (int i = 0; i < 40; i++) begin
			runClock = i < 20;
			@(posedge clk iff phase == 6);
			#1;
			chk("bypass bit", 32'(routeData), 32'(receiveSerialOutput));
		end
		end_of_test;
	end
endmodule
`default_nettype wire
